// ==== src/drive_status_defs.vh ====
`ifndef DRIVE_STATUS_DEFS_VH
`define DRIVE_STATUS_DEFS_VH

// ==========================================
// Timing
`define CLK_KHZ 100000
`define FLASH_HALF_MS 500
`define FLASH_CNT_W 32

// ==========================================
// Register byte addresses
`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_IRQ_STATUS 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_WORD01 8'h0C
`define REG_WORD23 8'h10
`define REG_LAMPS 8'h14
`define REG_DISPLAY 8'h18

// ==========================================
// Control register bits (write-one pulses)
`define CTRL_HIST_CLR 0
`define CTRL_DISP_ACK 1

// ==========================================
// Interrupt status bits
`define IRQ_W 4
`define IRQ_TRIP 0
`define IRQ_DUP_ADDR 1
`define IRQ_NET_ERR 2
`define IRQ_NET_TMO 3

// ==========================================
// Bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ==========================================
// Lamp modes
`define LAMP_OFF 3'h0
`define LAMP_GREEN 3'h1
`define LAMP_FLASH_GREEN 3'h2
`define LAMP_RED 3'h3
`define LAMP_FLASH_RED 3'h4

// ==========================================
// Status byte bit positions
`define ST_FWD 0
`define ST_REV 1
`define ST_TRIP 2
`define ST_ARRIVAL 4
`define ST_TERM_LO 5

// ==========================================
// State codes and trip codes
`define STATE_STOP 8'h00
`define STATE_RUN 8'h01
`define STATE_JOG 8'h02
`define STATE_COAST 8'h03
`define STATE_DC_BRAKE 8'h04
`define STATE_TRIP_SAVE 8'h09
`define STATE_TRIP 8'h0A
`define STATE_UNDERVOLT 8'h0B
`define STATE_TUNE_FIRST 8'h65
`define STATE_TUNE_LAST 8'h74
`define TRIP_NONE 8'h00
`define FATAL_TRIP_CODE_A 8'h0B
`define FATAL_TRIP_CODE_B 8'h0C

// ==========================================
// Scaling: raw inputs carry 8 fractional bits
`define FRAC_BITS 8
`define FREQ_SCALE 16'h0064
`define CURR_SCALE 16'h000A

`endif

// ==== src/bicolour_lamp.v ====
`include "drive_status_defs.vh"
`default_nettype none

module bicolour_lamp (
	input wire core_clk,
	input wire rst,
	input wire [2:0] mode,
	input wire flash_phase,
	output reg green,
	output reg red
);

// ==========================================
// Lamp drive
// Flash colours follow the shared phase so both lamps blink together
always @(posedge core_clk) begin
	if (rst) begin
		green <= 1'b0;
		red <= 1'b0;
	end else begin
		case (mode)
			`LAMP_GREEN: begin
				green <= 1'b1;
				red <= 1'b0;
			end
			`LAMP_FLASH_GREEN: begin
				green <= flash_phase;
				red <= 1'b0;
			end
			`LAMP_RED: begin
				green <= 1'b0;
				red <= 1'b1;
			end
			`LAMP_FLASH_RED: begin
				green <= 1'b0;
				red <= flash_phase;
			end
			default: begin
				green <= 1'b0;
				red <= 1'b0;
			end
		endcase
	end
end

endmodule
`default_nettype wire

// ==== src/drive_status_produced_data.v ====
// Summary of operation
// - Module lamp: green, flash green, flash red, off
// - Module lamp steady red only on fatal trips
// - Network lamp shows online, idle, error, timeout, offline
// - All produced words zero after power-up idle
// - Word 0: status byte low, state code high
// - Scalars are unsigned value times scale factor
// - Word 1 is frequency in hundredths hertz
// - Word 2 is current in tenths ampere
// - Word 3 trip code, zero means none
// - Trip sets trip bit, loads trip code
// - Stop/reset clears trip bit, code stays
// - Stop/reset zeroes status run and arrival bits, frequency, current
// - Duplicate address shown while stopped, cleared run/key
// - Status byte bit layout
// - State code byte values
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`include "drive_status_defs.vh"
`default_nettype none

module drive_status_produced_data #(
	parameter [31:0] FLASH_HALF_CYCLES = `FLASH_HALF_MS * `CLK_KHZ
) (
	input wire core_clk,
	input wire rst,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output wire irq,
	// Drive core state
	input wire power_ok,
	input wire standby,
	input wire forward_running_flag,
	input wire reverse_running_flag,
	input wire freq_arrival,
	input wire [2:0] input_terminals,
	input wire [7:0] state_code,
	input wire [15:0] out_freq_hz_q8,
	input wire [15:0] out_current_a_q8,
	input wire trip_event,
	input wire [7:0] trip_code_in,
	input wire stop_reset,
	input wire key_press,
	// Network side
	input wire net_connected,
	input wire net_scanning,
	input wire net_critical_err,
	input wire net_timeout,
	input wire dup_addr_detect,
	input wire [5:0] own_node_addr,
	input wire poll_req,
	output reg poll_ack,
	output reg [15:0] produced_word0,
	output reg [15:0] produced_word1,
	output reg [15:0] produced_word2,
	output reg [15:0] produced_word3,
	// Lamps and display
	output wire module_state_lamp_green,
	output wire module_state_lamp_red,
	output wire network_state_lamp_green,
	output wire network_state_lamp_red,
	output reg show_node_addr,
	output reg [5:0] display_addr
);

// ==========================================
// Helpers
// Fixed-point to scaled integer, truncating toward zero
function [15:0] scale_q8;
	input [15:0] raw;
	input [15:0] factor;
	reg [31:0] prod;
	begin
		prod = raw * factor;
		scale_q8 = prod[`FRAC_BITS +: 16];
	end
endfunction

function is_fatal;
	input [7:0] code;
	begin
		is_fatal = (code == `FATAL_TRIP_CODE_A) || (code == `FATAL_TRIP_CODE_B);
	end
endfunction

// ==========================================
// Flash divider
reg [`FLASH_CNT_W-1:0] flash_cnt;
reg flash_phase;

// One-cycle tick every half period toggles the phase
always @(posedge core_clk) begin
	if (rst) begin
		flash_cnt <= {`FLASH_CNT_W{1'b0}};
		flash_phase <= 1'b0;
	end else if (flash_cnt == FLASH_HALF_CYCLES - 32'h0000_0001) begin
		flash_cnt <= {`FLASH_CNT_W{1'b0}};
		flash_phase <= ~flash_phase;
	end else begin
		flash_cnt <= flash_cnt + 32'h0000_0001;
	end
end

// ==========================================
// Trip retention and stopped state
reg trip_active;
reg [7:0] trip_code;
reg stopped;
wire hist_clr;
wire running;

assign running = forward_running_flag | reverse_running_flag;

// Trip bit and code; a trip in the clearing cycle wins
always @(posedge core_clk) begin
	if (rst) begin
		trip_active <= 1'b0;
		trip_code <= `TRIP_NONE;
	end else begin
		if (trip_event) begin
			trip_active <= 1'b1;
			trip_code <= trip_code_in;
		end else begin
			// Stop/reset is ignored while trip history is being saved
			if (stop_reset && state_code != `STATE_TRIP_SAVE)
				trip_active <= 1'b0;
			if (hist_clr)
				trip_code <= `TRIP_NONE;
		end
	end
end

// Stop/reset blanks live values until the motor runs again
always @(posedge core_clk) begin
	if (rst)
		stopped <= 1'b1;
	else if (stop_reset)
		stopped <= 1'b1;
	else if (running)
		stopped <= 1'b0;
end

// ==========================================
// Produced image snapshot
wire [7:0] status_byte;
wire [15:0] live_word0;
wire [15:0] live_word1;
wire [15:0] live_word2;

assign status_byte = {input_terminals, freq_arrival & ~stopped, 1'b0, trip_active,
	reverse_running_flag & ~stopped, forward_running_flag & ~stopped};
assign live_word0 = {state_code, status_byte};
assign live_word1 = stopped ? 16'h0000 : scale_q8(out_freq_hz_q8, `FREQ_SCALE);
assign live_word2 = stopped ? 16'h0000 : scale_q8(out_current_a_q8, `CURR_SCALE);

// Whole image captured on one edge so the host never sees a mix
always @(posedge core_clk) begin
	if (rst) begin
		produced_word0 <= 16'h0000;
		produced_word1 <= 16'h0000;
		produced_word2 <= 16'h0000;
		produced_word3 <= 16'h0000;
		poll_ack <= 1'b0;
	end else begin
		poll_ack <= poll_req;
		if (poll_req) begin
			produced_word0 <= live_word0;
			produced_word1 <= live_word1;
			produced_word2 <= live_word2;
			produced_word3 <= {8'h00, trip_code};
		end
	end
end

// ==========================================
// Duplicate node address display
wire disp_ack;

// Shown only while stopped; run or a key press restores the display
always @(posedge core_clk) begin
	if (rst) begin
		show_node_addr <= 1'b0;
		display_addr <= 6'h00;
	end else if (running || key_press || disp_ack) begin
		show_node_addr <= 1'b0;
	end else if (dup_addr_detect && state_code == `STATE_STOP) begin
		show_node_addr <= 1'b1;
		display_addr <= own_node_addr;
	end
end

// ==========================================
// Lamp modes
reg [2:0] ms_mode;
reg [2:0] ns_mode;

// Fatal codes take priority over flashing trip red
always @* begin
	if (!power_ok)
		ms_mode = `LAMP_OFF;
	else if (trip_active && is_fatal(trip_code))
		ms_mode = `LAMP_RED;
	else if (trip_active)
		ms_mode = `LAMP_FLASH_RED;
	else if (standby)
		ms_mode = `LAMP_FLASH_GREEN;
	else
		ms_mode = `LAMP_GREEN;
end

// Errors outrank link state; scanning turns idle into online
always @* begin
	if (!power_ok)
		ns_mode = `LAMP_OFF;
	else if (net_critical_err)
		ns_mode = `LAMP_RED;
	else if (net_timeout)
		ns_mode = `LAMP_FLASH_RED;
	else if (net_connected && net_scanning)
		ns_mode = `LAMP_GREEN;
	else if (net_connected)
		ns_mode = `LAMP_FLASH_GREEN;
	else
		ns_mode = `LAMP_OFF;
end

bicolour_lamp module_lamp (
	.core_clk(core_clk),
	.rst(rst),
	.mode(ms_mode),
	.flash_phase(flash_phase),
	.green(module_state_lamp_green),
	.red(module_state_lamp_red)
);

bicolour_lamp network_lamp (
	.core_clk(core_clk),
	.rst(rst),
	.mode(ns_mode),
	.flash_phase(flash_phase),
	.green(network_state_lamp_green),
	.red(network_state_lamp_red)
);

// ==========================================
// AXI4-Lite write path
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire wr_fire;
wire wr_hit;

assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
assign s_axi_wready = ~w_held & ~s_axi_bvalid;
assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
assign wr_hit = (aw_addr == `REG_CTRL) || (aw_addr == `REG_IRQ_STATUS) ||
	(aw_addr == `REG_IRQ_MASK);
assign hist_clr = wr_fire && aw_addr == `REG_CTRL && w_strb[0] && w_data[`CTRL_HIST_CLR];
assign disp_ack = wr_fire && aw_addr == `REG_CTRL && w_strb[0] && w_data[`CTRL_DISP_ACK];

// Address and data latched in either order; response after both
always @(posedge core_clk) begin
	if (rst) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h0000_0000;
		w_strb <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ==========================================
// Interrupt status and mask
reg [`IRQ_W-1:0] irq_status;
reg [`IRQ_W-1:0] irq_mask;
reg net_err_d;
reg net_tmo_d;
wire [`IRQ_W-1:0] irq_set;
wire [`IRQ_W-1:0] irq_clr;

assign irq_set = {net_timeout & ~net_tmo_d, net_critical_err & ~net_err_d,
	dup_addr_detect, trip_event};
assign irq_clr = (wr_fire && aw_addr == `REG_IRQ_STATUS && w_strb[0]) ?
	w_data[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
assign irq = |(irq_status & irq_mask);

// Set beats a write-one clear in the same cycle
always @(posedge core_clk) begin
	if (rst) begin
		irq_status <= {`IRQ_W{1'b0}};
		irq_mask <= {`IRQ_W{1'b0}};
		net_err_d <= 1'b0;
		net_tmo_d <= 1'b0;
	end else begin
		net_err_d <= net_critical_err;
		net_tmo_d <= net_timeout;
		irq_status <= (irq_status & ~irq_clr) | irq_set;
		if (wr_fire && aw_addr == `REG_IRQ_MASK && w_strb[0])
			irq_mask <= w_data[`IRQ_W-1:0];
	end
end

// ==========================================
// AXI4-Lite read path
assign s_axi_arready = ~s_axi_rvalid;

// Single outstanding read, data one cycle after the address
always @(posedge core_clk) begin
	if (rst) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0000_0000;
		s_axi_rresp <= `RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= `RESP_OKAY;
		case ({s_axi_araddr[7:2], 2'b00})
			`REG_CTRL: s_axi_rdata <= 32'h0000_0000;
			`REG_IRQ_STATUS: s_axi_rdata <= {28'h0000000, irq_status};
			`REG_IRQ_MASK: s_axi_rdata <= {28'h0000000, irq_mask};
			`REG_WORD01: s_axi_rdata <= {produced_word1, produced_word0};
			`REG_WORD23: s_axi_rdata <= {produced_word3, produced_word2};
			`REG_LAMPS: s_axi_rdata <= {26'h0000000, ns_mode, ms_mode};
			`REG_DISPLAY: s_axi_rdata <= {25'h0000000, show_node_addr, display_addr};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `RESP_SLVERR;
			end
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule
`default_nettype wire

// ==== bench/host_scanner_model.sv ====
`default_nettype none
// ==========================================
// Network host scanner stand-in
module host_scanner_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scan_on,
	input wire logic poll_go,
	output logic net_scanning,
	output logic poll_req
);
	timeunit 1ns;
	timeprecision 1ps;
	// Scan level and a one-cycle poll; quiet in reset so no poll leaks early
	always @(posedge core_clk) begin
		net_scanning <= scan_on & ~rst;
		poll_req <= poll_go & ~rst;
	end
endmodule
`default_nettype wire

// ==== bench/drive_status_monitor.sv ====
`default_nettype none
// ==========================================
// Port checker for the status block
module drive_status_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic power_ok,
	input wire logic forward_running_flag,
	input wire logic reverse_running_flag,
	input wire logic [2:0] input_terminals,
	input wire logic [7:0] state_code,
	input wire logic [15:0] out_freq_hz_q8,
	input wire logic [15:0] out_current_a_q8,
	input wire logic trip_event,
	input wire logic [7:0] trip_code_in,
	input wire logic stop_reset,
	input wire logic key_press,
	input wire logic net_connected,
	input wire logic net_scanning,
	input wire logic net_critical_err,
	input wire logic net_timeout,
	input wire logic dup_addr_detect,
	input wire logic [5:0] own_node_addr,
	input wire logic poll_req,
	input wire logic poll_ack,
	input wire logic [15:0] produced_word0,
	input wire logic [15:0] produced_word1,
	input wire logic [15:0] produced_word2,
	input wire logic [15:0] produced_word3,
	input wire logic module_state_lamp_green,
	input wire logic module_state_lamp_red,
	input wire logic network_state_lamp_green,
	input wire logic network_state_lamp_red,
	input wire logic show_node_addr,
	input wire logic [5:0] display_addr
);
	logic [3:0] run_age;
	logic tripped;
	logic [7:0] trip_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Unsigned value times scale, fraction dropped
	function automatic logic [15:0] scaled(input logic [15:0] x, input logic [7:0] f);
		logic [23:0] p;
		p = x * f;
		return p[23:8];
	endfunction
	// Run age: any stop/reset zeroes it, a run flag level restarts it
	always @(posedge core_clk)
		if (rst || stop_reset)
			run_age <= 4'h0;
		else if (run_age == 4'h0 ? (forward_running_flag | reverse_running_flag)
			: run_age != 4'hF)
			run_age <= run_age + 4'h1;
	// Outstanding trip and its code; a new trip beats a same-cycle stop
	always @(posedge core_clk)
		if (rst)
			tripped <= 1'b0;
		else if (trip_event) begin
			tripped <= 1'b1;
			trip_q <= trip_code_in;
		end else if (stop_reset && state_code != 8'h09)
			tripped <= 1'b0;
	chk_stopped_words: assert property (poll_req && run_age == 4'h0 |=>
		produced_word1 == 16'h0000 && produced_word2 == 16'h0000 &&
		produced_word0[4] == 1'b0 && produced_word0[1:0] == 2'b00)
		else $error("words not zero while stopped");
	chk_scaled_values: assert property (poll_req && run_age > 4'h1 |=>
		produced_word1 == scaled($past(out_freq_hz_q8), 8'd100) &&
		produced_word2 == scaled($past(out_current_a_q8), 8'd10))
		else $error("scaled frequency or current wrong");
	chk_word0_layout: assert property (poll_req |=> poll_ack &&
		produced_word0[15:8] == $past(state_code) &&
		produced_word0[7:5] == $past(input_terminals) && !produced_word0[3])
		else $error("word0 layout wrong");
	chk_trip_loads: assert property (poll_req && tripped |=>
		produced_word0[2] && produced_word3 == trip_q)
		else $error("trip bit or code missing");
	chk_trip_clears: assert property (poll_req && !tripped |=> !produced_word0[2])
		else $error("trip bit not cleared");
	chk_lamps_dark: assert property ((!power_ok)[*3] |=> !module_state_lamp_green &&
		!module_state_lamp_red && !network_state_lamp_green && !network_state_lamp_red)
		else $error("lamps lit without power");
	chk_net_online: assert property ((power_ok && net_connected && net_scanning &&
		!net_critical_err && !net_timeout)[*3] |=> network_state_lamp_green &&
		!network_state_lamp_red)
		else $error("network lamp not green");
	chk_net_critical: assert property ((power_ok && net_critical_err)[*3] |=>
		network_state_lamp_red && !network_state_lamp_green)
		else $error("network lamp not red");
	chk_dup_shows: assert property (dup_addr_detect && state_code == 8'h00 && !key_press &&
		!forward_running_flag && !reverse_running_flag |=>
		show_node_addr && display_addr == $past(own_node_addr))
		else $error("address not shown");
	chk_key_hides: assert property (key_press |=> !show_node_addr)
		else $error("address display not cleared");
endmodule
`default_nettype wire

// ==== bench/drive_status_produced_data_tb_top.sv ====
`default_nettype none
// ==========================================
// Bench top
module drive_status_produced_data_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, power_ok = 1, standby = 0, poll_go = 0;
	logic forward_running_flag = 0, reverse_running_flag = 0, freq_arrival = 0;
	logic trip_event = 0, stop_reset = 0, key_press = 0, net_connected = 0, scan_on = 0;
	logic net_critical_err = 0, net_timeout = 0, dup_addr_detect = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, state_code = 0, trip_code_in = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] input_terminals = 0;
	logic [15:0] out_freq_hz_q8 = 0, out_current_a_q8 = 0;
	logic [5:0] own_node_addr = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire poll_req, poll_ack, net_scanning, show_node_addr, module_state_lamp_green;
	wire module_state_lamp_red, network_state_lamp_green, network_state_lamp_red;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] produced_word0, produced_word1, produced_word2, produced_word3;
	wire [5:0] display_addr;
	int bad_count = 0;
	int n_compared = 0;
	logic [7:0] codes [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0A, 8'h0B, 8'h65, 8'h74};
	logic [2:0] ns_mode [4] = '{3'h2, 3'h1, 3'h4, 3'h3};
	// Short flash period keeps lamp phases quick
	drive_status_produced_data #(.FLASH_HALF_CYCLES(32'd4)) drive_status_produced_data_i (.*);
	host_scanner_model host_scanner_model_i (.core_clk, .rst, .scan_on, .poll_go,
		.net_scanning, .poll_req);
	// 100 MHz clock
	initial forever #5 core_clk = ~core_clk;
	// ==========================================
	// Tasks
	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic summarize();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Address and data offered together; each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata}, {er, exp});
	endtask
	// One host poll, words taken in the acknowledge cycle
	task automatic poll(input logic [15:0] e0, e1, e2, e3);
		@(posedge core_clk);
		poll_go <= 1'b1;
		@(posedge core_clk);
		poll_go <= 1'b0;
		do @(posedge core_clk); while (!poll_ack);
		chk({produced_word1, produced_word0}, {e1, e0});
		chk({produced_word3, produced_word2}, {e3, e2});
	endtask
	// Lit cycles of the module lamp over one flash period
	task automatic blink(input logic [7:0] exp_g, input logic [7:0] exp_r);
		int g = 0;
		int r = 0;
		repeat (8) begin
			@(posedge core_clk);
			g += module_state_lamp_green;
			r += module_state_lamp_red;
		end
		chk({g[7:0], r[7:0]}, {exp_g, exp_r});
	endtask
	// Watchdog well beyond the expected run
	initial begin
		cyc(20000);
		bad_count++;
		summarize();
	end
	// ==========================================
	// Tests
	initial begin
		cyc(20);
		rst <= 1'b0;
		poll(16'h0000, 16'h0000, 16'h0000, 16'h0000);
		rd(8'h14, 32'h01, 2'b00);
		blink(8'd8, 8'd0);
		for (int i = 0; i < 4; i++) begin
			net_connected <= 1'b1;
			scan_on <= i > 0;
			net_timeout <= i > 1;
			net_critical_err <= i > 2;
			cyc(3);
			rd(8'h14, {26'h0, ns_mode[i], 3'h1}, 2'b00);
		end
		power_ok <= 1'b0;
		cyc(4);
		rd(8'h14, 32'h00, 2'b00);
		power_ok <= 1'b1;
		net_critical_err <= 1'b0;
		net_timeout <= 1'b0;
		standby <= 1'b1;
		cyc(3);
		rd(8'h14, 32'h0A, 2'b00);
		blink(8'd4, 8'd0);
		standby <= 1'b0;
		$display("lamp test done");
		own_node_addr <= 6'h2A;
		dup_addr_detect <= 1'b1;
		cyc(1);
		dup_addr_detect <= 1'b0;
		rd(8'h18, 32'h6A, 2'b00);
		key_press <= 1'b1;
		cyc(1);
		key_press <= 1'b0;
		cyc(2);
		chk(show_node_addr, 1'b0);
		dup_addr_detect <= 1'b1;
		cyc(1);
		dup_addr_detect <= 1'b0;
		wr(8'h00, 32'h02, 2'b00);
		rd(8'h18, 32'h2A, 2'b00);
		rd(8'h04, 32'h0E, 2'b00);
		wr(8'h04, 32'h0F, 2'b00);
		rd(8'h04, 32'h00, 2'b00);
		rd(8'h1C, 32'h00, 2'b10);
		wr(8'h20, 32'h01, 2'b10);
		$display("display and bus test done");
		state_code <= 8'h01;
		freq_arrival <= 1'b1;
		out_freq_hz_q8 <= 16'h0F00;
		out_current_a_q8 <= 16'h011A;
		forward_running_flag <= 1'b1;
		cyc(2);
		poll(16'h0111, 16'h05DC, 16'h000B, 16'h0000);
		forward_running_flag <= 1'b0;
		reverse_running_flag <= 1'b1;
		input_terminals <= 3'b101;
		out_freq_hz_q8 <= 16'hFFFF;
		out_current_a_q8 <= 16'hFFFF;
		for (int i = 0; i < 9; i++) begin
			state_code <= codes[i];
			poll({codes[i], 8'hB2}, 16'h63FF, 16'h09FF, 16'h0000);
		end
		$display("run test done");
		trip_code_in <= 8'h05;
		trip_event <= 1'b1;
		state_code <= 8'h0A;
		cyc(1);
		trip_event <= 1'b0;
		poll(16'h0AB6, 16'h63FF, 16'h09FF, 16'h0005);
		rd(8'h14, 32'h0C, 2'b00);
		blink(8'd0, 8'd4);
		chk(irq, 1'b0);
		wr(8'h08, 32'h01, 2'b00);
		chk(irq, 1'b1);
		reverse_running_flag <= 1'b0;
		state_code <= 8'h00;
		stop_reset <= 1'b1;
		cyc(1);
		stop_reset <= 1'b0;
		poll(16'h00A0, 16'h0000, 16'h0000, 16'h0005);
		wr(8'h04, 32'h01, 2'b00);
		chk(irq, 1'b0);
		wr(8'h00, 32'h01, 2'b00);
		poll(16'h00A0, 16'h0000, 16'h0000, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			trip_code_in <= 8'h0B + 8'(i);
			trip_event <= 1'b1;
			cyc(1);
			trip_event <= 1'b0;
			cyc(3);
			rd(8'h14, 32'h0B, 2'b00);
			blink(8'd0, 8'd8);
			stop_reset <= 1'b1;
			cyc(1);
			stop_reset <= 1'b0;
		end
		$display("trip test done");
		summarize();
	end
endmodule
bind drive_status_produced_data drive_status_monitor drive_status_monitor_i (.*);
`default_nettype wire
